// [hw/beterm_pkg.sv]
// shared constants for the bus error termination master and slave ends
package beterm_pkg;
	// ----------------------------------------
	// transfer type and response encodings
	// ----------------------------------------
	localparam logic [1:0] BETERM_TRANS_IDLE = 2'h0;
	localparam logic [1:0] BETERM_TRANS_NONSEQ = 2'h2;
	localparam logic [2:0] BETERM_RESP_OKAY = 3'h0;
	localparam logic [2:0] BETERM_RESP_ERROR = 3'h1;
	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int BETERM_AW = 32;
	localparam int BETERM_DW = 32;
	localparam logic [31:0] BETERM_DATA_RST = 32'h0000_0000;
	// slave wait states before answering, fixed
	localparam logic [3:0] BETERM_WAIT_RST = 4'h0;
endpackage

// [hw/beterm_if.sv]
// bus interface joining the master and the slave ends
`timescale 1ns/1ps
`default_nettype none
interface beterm_if;
	import beterm_pkg::*;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic [2:0] hresp;
	modport master (output htrans, output hwrite, output haddr, output hwdata,
		input hrdata, input hready, input hresp);
	modport slave (input htrans, input hwrite, input haddr, input hwdata,
		output hrdata, output hready, output hresp);
endinterface
`default_nettype wire

// [hw/beterm_master.sv]
// bus master end: requests, error termination, retraction and error report
//
// Function
// - slave flags failure with ERROR plus ready
// - error ends in two cycles, ready second
// - ERROR shown with ready low first
// - master may idle or re-request in second
// - pending request may change after error
// - read data on error is discarded
// - request on idle bus taken same cycle
// - no request taken while access outstanding
// - after fetch error, next read stays requested
// - after data read error, write retracted
// - misaligned write second portion aborted on error
// - new request taken as previous terminates
// - normal read data comes cycle after taking
`timescale 1ns/1ps
`default_nettype none
module beterm_master
	import beterm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// user request side
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_fetch_i,
	input wire logic req_split_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [31:0] req_addr2_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic [31:0] req_wdata2_i,
	output logic req_ready_o,
	// user answer side
	output logic rsp_valid_o,
	output logic [31:0] rsp_rdata_o,
	output logic rsp_error_o,
	output logic err_fetch_o,
	output logic err_data_o,
	// bus
	beterm_if.master bus
);
	typedef enum logic [1:0] {
		BETERM_ST_IDLE = 2'b00,
		BETERM_ST_BUSY = 2'b01
	} beterm_state_t;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	beterm_state_t state_r, state_nxt;
	logic [1:0] htrans_r, htrans_nxt;
	logic hwrite_r, hwrite_nxt;
	logic [31:0] haddr_r, haddr_nxt;
	logic [31:0] hwdata_r, hwdata_nxt;
	logic [31:0] wdata_q_r, wdata_q_nxt;
	logic dph_write_r, dph_write_nxt;
	logic dph_fetch_r, dph_fetch_nxt;
	logic aph_fetch_r, aph_fetch_nxt;
	logic aph_write_r, aph_write_nxt;
	logic split_pend_r, split_pend_nxt;
	logic [31:0] addr2_r, addr2_nxt;
	logic [31:0] wdata2_r, wdata2_nxt;
	logic req_ready_r, req_ready_nxt;
	logic rsp_valid_r, rsp_valid_nxt;
	logic [31:0] rsp_rdata_r, rsp_rdata_nxt;
	logic rsp_error_r, rsp_error_nxt;
	logic err_fetch_r, err_fetch_nxt;
	logic err_data_r, err_data_nxt;
	logic taken, err_first, err_done, ok_done, drive_new;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		htrans_nxt = htrans_r;
		hwrite_nxt = hwrite_r;
		haddr_nxt = haddr_r;
		hwdata_nxt = hwdata_r;
		wdata_q_nxt = wdata_q_r;
		dph_write_nxt = dph_write_r;
		dph_fetch_nxt = dph_fetch_r;
		aph_fetch_nxt = aph_fetch_r;
		aph_write_nxt = aph_write_r;
		split_pend_nxt = split_pend_r;
		addr2_nxt = addr2_r;
		wdata2_nxt = wdata2_r;
		rsp_valid_nxt = 1'b0;
		rsp_rdata_nxt = rsp_rdata_r;
		rsp_error_nxt = 1'b0;
		err_fetch_nxt = 1'b0;
		err_data_nxt = 1'b0;
		drive_new = 1'b0;
		// request on bus is taken when no access outstanding or it ends
		taken = (htrans_r == BETERM_TRANS_NONSEQ) &&
			((state_r == BETERM_ST_IDLE) || bus.hready);
		ok_done = (state_r == BETERM_ST_BUSY) && bus.hready && (bus.hresp == BETERM_RESP_OKAY);
		err_first = (state_r == BETERM_ST_BUSY) && !bus.hready && (bus.hresp == BETERM_RESP_ERROR);
		err_done = (state_r == BETERM_ST_BUSY) && bus.hready && (bus.hresp == BETERM_RESP_ERROR);
		// data phase completion
		if (ok_done) begin
			rsp_valid_nxt = 1'b1;
			if (!dph_write_r) begin
				rsp_rdata_nxt = bus.hrdata;
			end
		end
		if (err_done) begin
			rsp_valid_nxt = 1'b1;
			rsp_error_nxt = 1'b1; // read data ignored
			err_fetch_nxt = dph_fetch_r;
			err_data_nxt = !dph_fetch_r;
		end
		if (ok_done || err_done) begin
			state_nxt = BETERM_ST_IDLE;
		end
		// address phase handover
		if (taken) begin
			state_nxt = BETERM_ST_BUSY;
			dph_write_nxt = hwrite_r;
			dph_fetch_nxt = aph_fetch_r;
			hwdata_nxt = wdata_q_r;
			htrans_nxt = BETERM_TRANS_IDLE;
			if (split_pend_r) begin
				// second portion of misaligned write
				htrans_nxt = BETERM_TRANS_NONSEQ;
				haddr_nxt = addr2_r;
				wdata_q_nxt = wdata2_r;
				split_pend_nxt = 1'b0;
			end else begin
				drive_new = 1'b1;
			end
		end else if (err_first && (htrans_r == BETERM_TRANS_NONSEQ)) begin
			// retract pending access after a data error; after a fetch error keep a pending read
			if (!dph_fetch_r || split_pend_r || aph_write_r) begin
				htrans_nxt = BETERM_TRANS_IDLE;
				split_pend_nxt = 1'b0;
			end // pending read stays requested
		end else if (err_first && split_pend_r) begin
			split_pend_nxt = 1'b0;
		end else if (htrans_r == BETERM_TRANS_IDLE) begin
			drive_new = 1'b1;
		end
		// present a new user request; not while the last one is acknowledged,
		// as the user still holds it in that cycle and would be loaded twice
		if (drive_new && req_valid_i && !req_ready_r) begin
			htrans_nxt = BETERM_TRANS_NONSEQ;
			hwrite_nxt = req_write_i;
			haddr_nxt = req_addr_i;
			wdata_q_nxt = req_wdata_i;
			aph_fetch_nxt = req_fetch_i;
			aph_write_nxt = req_write_i;
			split_pend_nxt = req_split_i && req_write_i;
			addr2_nxt = req_addr2_i;
			wdata2_nxt = req_wdata2_i;
		end
		req_ready_nxt = 1'b0;
		if (drive_new && req_valid_i && !req_ready_r) begin
			req_ready_nxt = 1'b1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= BETERM_ST_IDLE;
			htrans_r <= BETERM_TRANS_IDLE;
			hwrite_r <= 1'b0;
			haddr_r <= BETERM_DATA_RST;
			hwdata_r <= BETERM_DATA_RST;
			wdata_q_r <= BETERM_DATA_RST;
			dph_write_r <= 1'b0;
			dph_fetch_r <= 1'b0;
			aph_fetch_r <= 1'b0;
			aph_write_r <= 1'b0;
			split_pend_r <= 1'b0;
			addr2_r <= BETERM_DATA_RST;
			wdata2_r <= BETERM_DATA_RST;
			req_ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_rdata_r <= BETERM_DATA_RST;
			rsp_error_r <= 1'b0;
			err_fetch_r <= 1'b0;
			err_data_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			htrans_r <= htrans_nxt;
			hwrite_r <= hwrite_nxt;
			haddr_r <= haddr_nxt;
			hwdata_r <= hwdata_nxt;
			wdata_q_r <= wdata_q_nxt;
			dph_write_r <= dph_write_nxt;
			dph_fetch_r <= dph_fetch_nxt;
			aph_fetch_r <= aph_fetch_nxt;
			aph_write_r <= aph_write_nxt;
			split_pend_r <= split_pend_nxt;
			addr2_r <= addr2_nxt;
			wdata2_r <= wdata2_nxt;
			req_ready_r <= req_ready_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_rdata_r <= rsp_rdata_nxt;
			rsp_error_r <= rsp_error_nxt;
			err_fetch_r <= err_fetch_nxt;
			err_data_r <= err_data_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.htrans = htrans_r;
	assign bus.hwrite = hwrite_r;
	assign bus.haddr = haddr_r;
	assign bus.hwdata = hwdata_r;
	assign req_ready_o = req_ready_r;
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_rdata_o = rsp_rdata_r;
	assign rsp_error_o = rsp_error_r;
	assign err_fetch_o = err_fetch_r;
	assign err_data_o = err_data_r;
endmodule
`default_nettype wire

// [hw/beterm_slave.sv]
// bus slave end: one-cycle okay answer or two-cycle error termination
`timescale 1ns/1ps
`default_nettype none
module beterm_slave
	import beterm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// user side: memory answer and error choice
	input wire logic [31:0] mem_rdata_i,
	input wire logic fail_i,
	output logic acc_valid_o,
	output logic acc_write_o,
	output logic [31:0] acc_addr_o,
	output logic [31:0] acc_wdata_o,
	// bus
	beterm_if.slave bus
);
	typedef enum logic [1:0] {
		BETERM_SL_IDLE = 2'b00,
		BETERM_SL_DATA = 2'b01,
		BETERM_SL_ERR2 = 2'b10,
		BETERM_SL_ERR1 = 2'b11
	} beterm_sl_state_t;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	beterm_sl_state_t state_r, state_nxt;
	logic hready_r, hready_nxt;
	logic [2:0] hresp_r, hresp_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic dph_write_r, dph_write_nxt;
	logic [31:0] dph_addr_r, dph_addr_nxt;
	logic acc_valid_r, acc_valid_nxt;
	logic acc_write_r, acc_write_nxt;
	logic [31:0] acc_addr_r, acc_addr_nxt;
	logic [31:0] acc_wdata_r, acc_wdata_nxt;
	logic take;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = BETERM_SL_IDLE;
		hready_nxt = 1'b1;
		hresp_nxt = BETERM_RESP_OKAY;
		hrdata_nxt = hrdata_r;
		dph_write_nxt = dph_write_r;
		dph_addr_nxt = dph_addr_r;
		acc_valid_nxt = 1'b0;
		acc_write_nxt = acc_write_r;
		acc_addr_nxt = acc_addr_r;
		acc_wdata_nxt = acc_wdata_r;
		// taken when idle, or as the current access ends
		take = (bus.htrans == BETERM_TRANS_NONSEQ) && bus.hready;
		case (state_r)
			BETERM_SL_IDLE: begin
			end
			BETERM_SL_DATA: begin
				// okay data phase: write data is on bus now
				acc_valid_nxt = 1'b1;
				acc_write_nxt = dph_write_r;
				acc_addr_nxt = dph_addr_r;
				acc_wdata_nxt = bus.hwdata;
			end
			BETERM_SL_ERR1: begin
				// second error cycle: ready with error still driven
				hresp_nxt = BETERM_RESP_ERROR;
				hrdata_nxt = BETERM_DATA_RST; // undefined on error
				state_nxt = BETERM_SL_ERR2;
			end
			BETERM_SL_ERR2: begin
			end
			default: begin
			end
		endcase
		// address phase accepted; the choice of answer is made here so the
		// first error cycle is the very data phase cycle
		if (take) begin
			dph_write_nxt = bus.hwrite;
			dph_addr_nxt = bus.haddr;
			if (fail_i) begin
				hready_nxt = 1'b0;
				hresp_nxt = BETERM_RESP_ERROR;
				state_nxt = BETERM_SL_ERR1;
			end else begin
				hrdata_nxt = mem_rdata_i;
				state_nxt = BETERM_SL_DATA;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= BETERM_SL_IDLE;
			hready_r <= 1'b1;
			hresp_r <= BETERM_RESP_OKAY;
			hrdata_r <= BETERM_DATA_RST;
			dph_write_r <= 1'b0;
			dph_addr_r <= BETERM_DATA_RST;
			acc_valid_r <= 1'b0;
			acc_write_r <= 1'b0;
			acc_addr_r <= BETERM_DATA_RST;
			acc_wdata_r <= BETERM_DATA_RST;
		end else begin
			state_r <= state_nxt;
			hready_r <= hready_nxt;
			hresp_r <= hresp_nxt;
			hrdata_r <= hrdata_nxt;
			dph_write_r <= dph_write_nxt;
			dph_addr_r <= dph_addr_nxt;
			acc_valid_r <= acc_valid_nxt;
			acc_write_r <= acc_write_nxt;
			acc_addr_r <= acc_addr_nxt;
			acc_wdata_r <= acc_wdata_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.hready = hready_r;
	assign bus.hresp = hresp_r;
	assign bus.hrdata = hrdata_r;
	assign acc_valid_o = acc_valid_r;
	assign acc_write_o = acc_write_r;
	assign acc_addr_o = acc_addr_r;
	assign acc_wdata_o = acc_wdata_r;
endmodule
`default_nettype wire

// [test/beterm_asserts.sv]
// bus checks between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module beterm_asserts
	import beterm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// bus
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hready,
	input wire logic [2:0] hresp
);
	// error phases and a taken request
	wire logic er1 = hresp == BETERM_RESP_ERROR && !hready;
	wire logic er2 = hresp == BETERM_RESP_ERROR && hready;
	wire logic take = htrans == BETERM_TRANS_NONSEQ && hready;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// termination shape
	property p_err_second; er1 |=> er2; endproperty
	a_err_second: assert property (p_err_second)
		else $error("error lacks ready cycle");
	property p_err_first; er2 |-> $past(er1); endproperty
	a_err_first: assert property (p_err_first)
		else $error("ready error without first cycle");
	property p_wait_err; !hready |-> hresp == BETERM_RESP_ERROR; endproperty
	a_wait_err: assert property (p_wait_err)
		else $error("wait without error code");
	property p_wait_one; $fell(hready) |=> $rose(hready); endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("wait longer than one cycle");
	// answers after a take or an idle cycle
	property p_take; take |=> (hready && hresp == BETERM_RESP_OKAY) || er1; endproperty
	a_take: assert property (p_take)
		else $error("taken access not answered next cycle");
	property p_idle; (htrans == BETERM_TRANS_IDLE && hready) |=> hready && hresp == BETERM_RESP_OKAY; endproperty
	a_idle: assert property (p_idle)
		else $error("answer without access");
	property p_err_data; er2 |-> hrdata == BETERM_DATA_RST; endproperty
	a_err_data: assert property (p_err_data)
		else $error("read data driven on error");
	// pending write dropped in second error cycle
	property p_retract; (er1 && htrans == BETERM_TRANS_NONSEQ && hwrite) |=> htrans == BETERM_TRANS_IDLE; endproperty
	a_retract: assert property (p_retract)
		else $error("pending write not retracted");
	// main scenarios
	c_retract: cover property (er1 && htrans == BETERM_TRANS_NONSEQ && hwrite);
	c_keep: cover property (er2 && take);
	c_back: cover property (take [*2]);
endmodule
`default_nettype wire

// [test/bus_error_termination_bench.sv]
// random and corner bench for the error termination ends
`timescale 1ns/1ps
`default_nettype none
module bus_error_termination_bench;
	import beterm_pkg::*;
	// stimulus, answers and logs
	logic sys_clk_i = 1'h0, reset_i = 1'h1, fail_i = 1'h0, req_valid_i = 1'h0;
	logic req_write_i = 1'h0, req_fetch_i = 1'h0, req_split_i = 1'h0;
	logic [31:0] req_addr_i = 32'h0000_0000, req_addr2_i = 32'h0000_0000, last_rd = 32'h0000_0000;
	logic [31:0] req_wdata_i = 32'h0000_0000, req_wdata2_i = 32'h0000_0000;
	logic req_ready_o, rsp_valid_o, rsp_error_o, err_fetch_o, err_data_o, acc_valid_o, acc_write_o;
	logic [31:0] rsp_rdata_o, acc_addr_o, acc_wdata_o;
	logic [64:0] rsp_q[$], rsp_x[$], acc_q[$], acc_x[$];
	int mismatches = 0, samples_checked = 0, seed = 32'he7cc719e;
	// memory contents seen by the slave
	function automatic logic [31:0] mem_of(input logic [31:0] a);
		return {a[15:0], ~a[31:16]};
	endfunction
	beterm_if bus_if ();
	beterm_master beterm_master_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_fetch_i(req_fetch_i), .req_split_i(req_split_i), .req_addr_i(req_addr_i),
		.req_addr2_i(req_addr2_i), .req_wdata_i(req_wdata_i), .req_wdata2_i(req_wdata2_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o), .err_fetch_o(err_fetch_o),
		.err_data_o(err_data_o), .bus(bus_if.master));
	beterm_slave beterm_slave_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mem_rdata_i(mem_of(bus_if.haddr)),
		.fail_i(fail_i), .acc_valid_o(acc_valid_o), .acc_write_o(acc_write_o), .acc_addr_o(acc_addr_o),
		.acc_wdata_o(acc_wdata_o), .bus(bus_if.slave));
	beterm_asserts beterm_asserts_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .htrans(bus_if.htrans),
		.hwrite(bus_if.hwrite), .hrdata(bus_if.hrdata), .hready(bus_if.hready), .hresp(bus_if.hresp));
	// clock
	always #5 sys_clk_i = ~sys_clk_i;
	// log answers and accesses
	always @(posedge sys_clk_i) begin
		if (rsp_valid_o === 1'h1)
			rsp_q.push_back({30'h0, rsp_error_o, err_fetch_o, err_data_o, rsp_rdata_o});
		if (acc_valid_o === 1'h1)
			acc_q.push_back({acc_write_o, acc_addr_o, acc_write_o ? acc_wdata_o : 32'h0000_0000});
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [64:0] exp, input logic [64:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bound(input int n);
		if (n >= 40) begin
			mismatches++;
			stop_test();
		end
	endtask
	// hold a request until loaded, then note what must come back
	task automatic op(input logic w, f, s, fl);
		logic [31:0] a, a2, d, d2;
		int n;
		a = $random(seed);
		a2 = $random(seed);
		d = $random(seed);
		d2 = $random(seed);
		n = 0;
		req_valid_i <= 1'h1;
		req_write_i <= w;
		req_fetch_i <= f;
		req_split_i <= s;
		req_addr_i <= a;
		req_addr2_i <= a2;
		req_wdata_i <= d;
		req_wdata2_i <= d2;
		if (fl)
			fail_i <= 1'h1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (req_ready_o !== 1'h1 && n < 40);
		bound(n);
		// slave samples the failure choice at this same edge
		if (fl)
			fail_i <= 1'h0;
		if (fl)
			rsp_x.push_back({30'h0, 1'h1, f, !f, last_rd});
		else begin
			if (!w)
				last_rd = mem_of(a);
			rsp_x.push_back({33'h0, last_rd});
			acc_x.push_back({w, a, w ? d : 32'h0000_0000});
			if (s) begin
				rsp_x.push_back({33'h0, last_rd});
				acc_x.push_back({1'h1, a2, d2});
			end
		end
	endtask
	// let answers drain, then compare both logs
	task automatic settle(input string name);
		int n;
		n = 0;
		req_valid_i <= 1'h0;
		while (rsp_q.size() < rsp_x.size() && n < 40) begin
			@(posedge sys_clk_i);
			n++;
		end
		bound(n);
		repeat (4) @(posedge sys_clk_i);
		check("answers", 65'(rsp_x.size()), 65'(rsp_q.size()));
		check("accesses", 65'(acc_x.size()), 65'(acc_q.size()));
		foreach (rsp_x[i]) check("answer", rsp_x[i], rsp_q[i]);
		foreach (acc_x[i]) check("access", acc_x[i], acc_q[i]);
		rsp_q.delete();
		rsp_x.delete();
		acc_q.delete();
		acc_x.delete();
		$display("test %s done", name);
	endtask
	// corner cases first, then a random mix
	initial begin
		logic [31:0] r;
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'h0;
		op(1'h0, 1'h1, 1'h0, 1'h1);
		op(1'h0, 1'h0, 1'h0, 1'h0);
		op(1'h0, 1'h0, 1'h0, 1'h0);
		settle("fetch_error");
		op(1'h0, 1'h0, 1'h0, 1'h1);
		settle("read_error");
		op(1'h1, 1'h0, 1'h0, 1'h1);
		settle("write_error");
		op(1'h1, 1'h0, 1'h1, 1'h0);
		settle("split_write");
		op(1'h1, 1'h0, 1'h1, 1'h1);
		settle("split_error");
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			op(r[0], !r[0] && r[1], r[0] && r[2], r[4:3] == 2'h0);
			settle("random");
		end
		stop_test();
	end
endmodule
`default_nettype wire
